// *** core/nvsc_defines.svh ***
// timing counts and field constants for the nvsram host controller
`ifndef NVSC_DEFINES_SVH
`define NVSC_DEFINES_SVH
// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define NVSC_CLK_MHZ 20
`define NVSC_CLK_NS 50
`define NVSC_T_STRB_NS 50
`define NVSC_T_STRB_CYC (((`NVSC_T_STRB_NS) + (`NVSC_CLK_NS) - 1) / (`NVSC_CLK_NS))
`define NVSC_T_HSB_NS 15
`define NVSC_T_HSB_CYC (((`NVSC_T_HSB_NS) + (`NVSC_CLK_NS) - 1) / (`NVSC_CLK_NS))
`define NVSC_T_SS_US 100
`define NVSC_T_SS_CYC ((`NVSC_T_SS_US) * (`NVSC_CLK_MHZ))
`define NVSC_T_RECALL_US 200
`define NVSC_T_RECALL_CYC ((`NVSC_T_RECALL_US) * (`NVSC_CLK_MHZ))
`define NVSC_SEQ_LEN 6
`define NVSC_LANE_W 8
`endif

// *** core/nvsc_pkg.sv ***
// types for the nvsram host controller
package nvsc_pkg;
  // ----------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {NVSC_CMD_READ, NVSC_CMD_WRITE, NVSC_CMD_SOFT, NVSC_CMD_HWSTORE} nvsc_cmd_t;
  typedef enum {NVSC_IDLE, NVSC_SETUP, NVSC_STROBE, NVSC_GAP, NVSC_HSB, NVSC_WAIT} nvsc_state_t;
endpackage : nvsc_pkg

// *** core/nvsc_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module nvsc_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  input wire logic srst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] q_nxt;
  // first stage feeds only the second
  always_comb begin
    s1_nxt = d;
    q_nxt = s1_r;
  end
  // pins idle high, so reset to all ones
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_r <= '1;
      q <= '1;
    end else begin
      s1_r <= s1_nxt;
      q <= q_nxt;
    end
  end
endmodule : nvsc_sync

// *** core/nvsc_host.sv ***
// host controller driving nvsram strobes, soft sequences and hardware store
// Function
// - soft sequence steps are output-gate terminated reads, never writes
// - six reads to the fixed address series in prescribed order
// - write strobe stays high through all six sequence cycles
// - sixth read data may be invalid; host discards it
// - hardware store request drives busy pin low at least 15 ns
// - busy pin stays released high during ordinary reads and writes
`include "nvsc_defines.svh"
`timescale 1ns/1ps
module nvsc_host #(
  parameter int AW = 20,
  parameter int DW = 16,
  parameter bit X16 = 1'b1,
  parameter int SS_CYC = `NVSC_T_SS_CYC,
  parameter int RECALL_CYC = `NVSC_T_RECALL_CYC,
  parameter logic [AW*6-1:0] SEQ_ADDR = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // user command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire nvsc_pkg::nvsc_cmd_t cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_wdata,
  input wire logic [1:0] cmd_lane,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  output logic busy,
  // sram pins
  output logic [AW-1:0] mem_addr,
  output logic chip_select_n,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic upper_lane_select_n,
  output logic lower_lane_select_n,
  input wire logic [DW-1:0] dq_in,
  output logic [DW-1:0] dq_out,
  output logic dq_oe_n,
  // store request / busy open-drain pin
  input wire logic store_request_busy_in,
  output logic store_request_busy_out,
  output logic store_request_busy_oe_n
);
  import nvsc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // wide enough for the full store/recall wait, not just the recall part
  localparam int CW = $clog2(SS_CYC + RECALL_CYC + 2);
  localparam logic [CW-1:0] STRB_CYC = CW'(`NVSC_T_STRB_CYC);
  localparam logic [CW-1:0] HSB_CYC = CW'(`NVSC_T_HSB_CYC);
  localparam logic [2:0] SEQ_LAST = 3'(`NVSC_SEQ_LEN - 1);

  // address of one step of the soft sequence
  function automatic logic [AW-1:0] seq_addr(input logic [2:0] idx);
    seq_addr = SEQ_ADDR[AW*idx +: AW];
  endfunction : seq_addr

  // ----------------------------------------------------------------
  // pin inputs through synchronisers
  // ----------------------------------------------------------------
  logic [DW:0] pins_s;
  nvsc_sync #(.W(DW + 1)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({store_request_busy_in, dq_in}),
    .q(pins_s)
  );
  logic hsb_s;
  assign hsb_s = pins_s[DW];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  nvsc_state_t st_r, st_nxt;
  nvsc_cmd_t op_r, op_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [2:0] step_r, step_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] wdata_r, wdata_nxt;
  logic [1:0] lane_r, lane_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic rsp_r, rsp_nxt;
  logic cs_r, cs_nxt, we_r, we_nxt, oe_r, oe_nxt, drv_r, drv_nxt, hsb_r, hsb_nxt;

  assign cmd_ready = (st_r == NVSC_IDLE);

  // next-state logic for the whole transfer engine
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    lane_nxt = lane_r;
    rdata_nxt = rdata_r;
    rsp_nxt = 1'b0;
    cs_nxt = cs_r;
    we_nxt = we_r;
    oe_nxt = oe_r;
    drv_nxt = drv_r;
    hsb_nxt = hsb_r;
    case (st_r)
      NVSC_IDLE: begin
        if (cmd_valid) begin
          op_nxt = cmd_op;
          wdata_nxt = cmd_wdata;
          lane_nxt = X16 ? cmd_lane : 2'b11;
          step_nxt = 3'h0;
          cnt_nxt = STRB_CYC;
          if (cmd_op == NVSC_CMD_HWSTORE) begin
            hsb_nxt = 1'b1;
            cnt_nxt = HSB_CYC;
            st_nxt = NVSC_HSB;
          end else begin
            addr_nxt = (cmd_op == NVSC_CMD_SOFT) ? seq_addr(3'h0) : cmd_addr;
            st_nxt = NVSC_SETUP;
          end
        end
      end
      NVSC_SETUP: begin
        // address settles with chip select high before the strobe
        cs_nxt = 1'b1;
        if (op_r == NVSC_CMD_WRITE) begin
          we_nxt = 1'b1;
          drv_nxt = 1'b1;
        end else begin
          oe_nxt = 1'b1;
        end
        st_nxt = NVSC_STROBE;
      end
      NVSC_STROBE: begin
        // strobes stand for the counted pulse width, then all release together
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - CW'(1);
        end else begin
          cs_nxt = 1'b0;
          we_nxt = 1'b0;
          oe_nxt = 1'b0;
          st_nxt = NVSC_GAP;
        end
      end
      NVSC_GAP: begin
        // data held one cycle past end of write for hold time
        drv_nxt = 1'b0;
        // the second sync stage now holds data sampled while the strobe stood
        if (op_r == NVSC_CMD_READ) begin
          rdata_nxt = pins_s[DW-1:0];
        end
        if (op_r == NVSC_CMD_SOFT && step_r != SEQ_LAST) begin
          step_nxt = step_r + 3'h1;
          addr_nxt = seq_addr(step_r + 3'h1);
          cnt_nxt = STRB_CYC;
          st_nxt = NVSC_SETUP;
        end else if (op_r == NVSC_CMD_SOFT) begin
          cnt_nxt = CW'(SS_CYC + RECALL_CYC);
          st_nxt = NVSC_WAIT;
        end else begin
          rsp_nxt = 1'b1;
          st_nxt = NVSC_IDLE;
        end
      end
      NVSC_HSB: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - CW'(1);
        end else begin
          hsb_nxt = 1'b0;
          cnt_nxt = CW'(SS_CYC + RECALL_CYC);
          st_nxt = NVSC_WAIT;
        end
      end
      NVSC_WAIT: begin
        // no cycles issued while the device is busy; in a hardware store, pin high once past the store part ends early
        if (cnt_r != '0 && !(op_r == NVSC_CMD_HWSTORE && hsb_s && cnt_r < CW'(RECALL_CYC))) begin
          cnt_nxt = cnt_r - CW'(1);
        end else begin
          rsp_nxt = 1'b1;
          rdata_nxt = '0;
          st_nxt = NVSC_IDLE;
        end
      end
      default: st_nxt = NVSC_IDLE;
    endcase
  end

  // registers of the transfer engine
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= NVSC_IDLE;
      op_r <= NVSC_CMD_READ;
      cnt_r <= '0;
      step_r <= 3'h0;
      addr_r <= '0;
      wdata_r <= '0;
      lane_r <= 2'h0;
      rdata_r <= '0;
      rsp_r <= 1'b0;
      cs_r <= 1'b0;
      we_r <= 1'b0;
      oe_r <= 1'b0;
      drv_r <= 1'b0;
      hsb_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      lane_r <= lane_nxt;
      rdata_r <= rdata_nxt;
      rsp_r <= rsp_nxt;
      cs_r <= cs_nxt;
      we_r <= we_nxt;
      oe_r <= oe_nxt;
      drv_r <= drv_nxt;
      hsb_r <= hsb_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign mem_addr = addr_r;
  assign chip_select_n = ~cs_r;
  assign write_strobe_n = ~we_r;
  assign output_gate_n = ~oe_r;
  assign lower_lane_select_n = ~(cs_r & lane_r[0]);
  assign upper_lane_select_n = ~(cs_r & lane_r[1]);
  assign dq_out = wdata_r;
  assign dq_oe_n = ~drv_r;
  assign store_request_busy_out = 1'b0;
  assign store_request_busy_oe_n = ~hsb_r;
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdata_r;
  assign busy = (st_r != NVSC_IDLE);
endmodule : nvsc_host

// *** verification/nvsc_host_chk.sv ***
// pin and response checker for nvsc_host
`timescale 1ns/1ps
module nvsc_host_chk
  import nvsc_pkg::*;
(
  // user side
  input wire logic clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire nvsc_pkg::nvsc_cmd_t cmd_op,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_rdata,
  // pins
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  input wire logic dq_oe_n,
  input wire logic store_request_busy_oe_n
);
  logic seq_r;
  logic seq_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // soft window, acceptance up to its response
  always_comb begin
    seq_nxt = rsp_valid ? 1'b0 : seq_r;
    if (cmd_valid && cmd_ready && cmd_op == NVSC_CMD_SOFT) seq_nxt = 1'b1;
  end
  always_ff @(posedge clk) begin
    seq_r <= srst ? 1'b0 : seq_nxt;
  end
  property p_wr; !write_strobe_n |-> !dq_oe_n && !chip_select_n; endproperty
  a_wr: assert property (p_wr) else $error("write undriven");
  property p_ln; !(upper_lane_select_n && lower_lane_select_n) |-> !chip_select_n; endproperty
  a_ln: assert property (p_ln) else $error("stray lane");
  property p_hq; !chip_select_n |-> store_request_busy_oe_n; endproperty
  a_hq: assert property (p_hq) else $error("store pin in cycle");
  property p_hp; $fell(store_request_busy_oe_n) |=> !store_request_busy_oe_n; endproperty
  a_hp: assert property (p_hp) else $error("store pulse short");
  property p_lat; cmd_valid && cmd_ready && cmd_op == NVSC_CMD_READ |-> ##[5:6] rsp_valid; endproperty
  a_lat: assert property (p_lat) else $error("read late");
  property p_sw; seq_r |-> write_strobe_n && dq_oe_n; endproperty
  a_sw: assert property (p_sw) else $error("write in sequence");
  property p_so; seq_r && !chip_select_n |-> !output_gate_n; endproperty
  a_so: assert property (p_so) else $error("step not read");
  property p_sd; seq_r && rsp_valid |-> rsp_rdata == 16'h0000; endproperty
  a_sd: assert property (p_sd) else $error("last data kept");
endmodule : nvsc_host_chk
bind nvsc_host nvsc_host_chk u_chk (.clk, .srst, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid, .rsp_rdata,
  .chip_select_n, .write_strobe_n, .output_gate_n, .upper_lane_select_n, .lower_lane_select_n, .dq_oe_n,
  .store_request_busy_oe_n);

// *** verification/nvsc_sram_model.sv ***
// behavioural nvsram device
`timescale 1ns/1ps
module nvsc_sram_model #(
  parameter logic [119:0] SEQ = '0
) (
  // strobes
  input wire logic [19:0] mem_addr,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic upper_lane_select_n,
  input wire logic lower_lane_select_n,
  // data and store pin
  input wire logic [15:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic store_request_busy_oe_n,
  output logic [15:0] dq_in,
  output logic store_request_busy_in
);
  logic [15:0] mem [0:255];
  logic [15:0] flt = 16'hA5C3;
  logic dirty = 1'b0;
  logic lock = 1'b0;
  logic hold = 1'b0;
  int step = 0;
  int nseq = 0;
  // floating lines toggle so a stale value never passes
  always #50 flt = ~flt;
  // pulled up; host or device may pull low
  assign store_request_busy_in = store_request_busy_oe_n && !hold;
  // lanes drive only in an unlocked read
  always_comb begin
    dq_in = flt;
    if (!chip_select_n && write_strobe_n && !output_gate_n && !lock) begin
      if (!lower_lane_select_n) dq_in[7:0] = mem[mem_addr[7:0]][7:0];
      if (!upper_lane_select_n) dq_in[15:8] = mem[mem_addr[7:0]][15:8];
    end
  end
  // write mid-pulse; a write restarts the sequence
  always @(negedge write_strobe_n) begin
    #20;
    if (!chip_select_n && !lock && !dq_oe_n) begin
      if (!lower_lane_select_n) mem[mem_addr[7:0]][7:0] = dq_out[7:0];
      if (!upper_lane_select_n) mem[mem_addr[7:0]][15:8] = dq_out[15:8];
      dirty = 1'b1;
      step = 0;
    end
  end
  // six ordered reads; the sixth locks out I/O while storing
  always @(negedge output_gate_n) begin
    #20;
    if (!chip_select_n && write_strobe_n && !lock) begin
      step = (mem_addr == SEQ[step*20 +: 20]) ? step + 1 : int'(mem_addr == SEQ[19:0]);
      if (step == 6) begin
        step = 0;
        nseq++;
        lock = 1'b1;
        #1000 lock = 1'b0;
        dirty = 1'b0;
      end
    end
  end
  // store only after a write, else the pin is let go at once
  always @(negedge store_request_busy_oe_n) begin
    #15;
    if (dirty) begin
      hold = 1'b1;
      lock = 1'b1;
      // store outlasts the host's processing guard so a busy pin is seen
      #2000 hold = 1'b0;
      lock = 1'b0;
      dirty = 1'b0;
    end
  end
endmodule : nvsc_sram_model

// *** verification/nvsc_host_tb.sv ***
// testbench for nvsc_host
`timescale 1ns/1ps
module nvsc_host_tb;
  import nvsc_pkg::*;
  localparam logic [119:0] SEQ = {20'h000E5, 20'h000F1, 20'h00063, 20'h000B2, 20'h00041, 20'h00090};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  nvsc_cmd_t cmd_op = NVSC_CMD_READ;
  logic [19:0] cmd_addr = 20'h00000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [1:0] cmd_lane = 2'h3;
  logic cmd_ready, rsp_valid, chip_select_n, write_strobe_n, output_gate_n, dq_oe_n;
  logic upper_lane_select_n, lower_lane_select_n, store_request_busy_in, store_request_busy_oe_n;
  logic busy, store_request_busy_out;
  logic [15:0] rsp_rdata, dq_in, dq_out;
  logic [19:0] mem_addr;
  int mismatches = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  nvsc_host #(.SS_CYC(20), .RECALL_CYC(40), .SEQ_ADDR(SEQ)) DUT (.clk, .srst, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_addr, .cmd_wdata, .cmd_lane, .rsp_valid, .rsp_rdata, .busy, .mem_addr, .chip_select_n, .write_strobe_n,
    .output_gate_n, .upper_lane_select_n, .lower_lane_select_n, .dq_in, .dq_out, .dq_oe_n, .store_request_busy_in,
    .store_request_busy_out, .store_request_busy_oe_n);
  nvsc_sram_model #(.SEQ(SEQ)) u_mem (.mem_addr, .chip_select_n, .write_strobe_n, .output_gate_n,
    .upper_lane_select_n, .lower_lane_select_n, .dq_out, .dq_oe_n, .store_request_busy_oe_n, .dq_in,
    .store_request_busy_in);
  task automatic end_sim;
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one command, response awaited under a bound
  task automatic run(input nvsc_cmd_t op, input logic [19:0] a, input logic [15:0] d, input logic [1:0] ln,
    output int n);
    n = 0;
    @(posedge clk);
    #5;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_lane = ln;
    @(posedge clk);
    #5;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 4000) begin
      chk(16'h0000, 16'h0001);
      end_sim;
    end
  endtask : run
  // lane writes merge; a one-lane read returns its byte
  task automatic t_lanes;
    int n;
    run(NVSC_CMD_WRITE, 20'h00005, 16'h1234, 2'h3, n);
    run(NVSC_CMD_WRITE, 20'h00005, 16'hABCD, 2'h1, n);
    run(NVSC_CMD_READ, 20'h00005, 16'h0000, 2'h3, n);
    chk(rsp_rdata, 16'h12CD);
    run(NVSC_CMD_READ, 20'h00005, 16'h0000, 2'h2, n);
    chk({8'h00, rsp_rdata[15:8]}, 16'h0012);
  endtask : t_lanes
  // a dirty store holds the pin longer than a clean request
  task automatic t_hw;
    int d, c;
    run(NVSC_CMD_HWSTORE, 20'h00000, 16'h0000, 2'h3, d);
    chk(16'(u_mem.dirty), 16'h0000);
    run(NVSC_CMD_HWSTORE, 20'h00000, 16'h0000, 2'h3, c);
    chk(16'(c < d), 16'h0001);
  endtask : t_hw
  // one sequence is taken, its last data dropped, access resumes
  task automatic t_soft;
    int n;
    run(NVSC_CMD_SOFT, 20'h00000, 16'h0000, 2'h3, n);
    chk(rsp_rdata, 16'h0000);
    chk(16'(u_mem.nseq), 16'h0001);
    run(NVSC_CMD_READ, 20'h00005, 16'h0000, 2'h3, n);
    chk(rsp_rdata, 16'h12CD);
  endtask : t_soft
  initial begin
    repeat (12) @(posedge clk);
    #5;
    chk({8'h00, store_request_busy_out, busy, cmd_ready, chip_select_n, write_strobe_n, dq_oe_n,
      store_request_busy_oe_n, rsp_valid}, 16'h003E);
    srst = 1'b0;
    t_lanes;
    t_hw;
    t_soft;
    end_sim;
  end
endmodule : nvsc_host_tb
